/* design/eab_buf_ctl.sv */
// Bus address/data multiplexing and external buffer/latch control
// Operation
// RULE_01: Reset asynchronously brings all registers and state machines to defined state.
// RULE_02: System holds reset at least eight bus clocks.
// RULE_03: Upper 22 data lines also carry upper 22 address bits.
// RULE_04: Device controls transceivers and latches; data port floats during reset.
// RULE_05: Address inputs 11 and 10 are input only, slave decode use.
// RULE_06: Master drives address 9..2 onto bus, pipelined into next cycle.
// RULE_07: Slave must latch pipelined lower address and byte enables itself.
// RULE_08: Slave monitors address 9..2, 11..10 and enables; floats on reset.
// RULE_09: Decode slot I/O, shared registers, general I/O from given bits.
// RULE_10: Byte enables driven in master, inputs in slave, float on reset.
// RULE_11: Each master transfer places upper address and updates external latches.
// RULE_12: Strobe falls on rising edge one clock before start, low until end.
// RULE_13: Strobe held high in slave mode and on reset.
// RULE_14: Direction low toward bus, high toward device, high on reset.
// RULE_15: Three lane enables active at transfer times, high on reset.
// RULE_16: Enable only selected lanes; never enable while direction changes.
`timescale 1ns/1ps
`default_nettype none
module eab_buf_ctl
  import eab_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  input  wire eab_pkg::eab_mreq_s      mreq,
  output logic                         mreq_ack,
  output logic                         start_n,
  output logic                         master_busy,
  input  wire logic                    slave_cyc,
  input  wire logic                    slave_write,
  input  wire logic                    slave_rd_data_ok,
  output eab_pkg::eab_dec_s            io_dec,
  input  wire logic [31:0]             data_in,
  output logic      [31:0]             data_out,
  output logic                         data_oe,
  output logic      [31:0]             rdata,
  input  wire logic [1:0]              slave_upper_decode_address_inputs,
  input  wire logic [7:0]              lower_bus_address_lines_in,
  output logic      [7:0]              lower_bus_address_lines_out,
  output logic                         lower_bus_address_lines_oe,
  input  wire logic [3:0]              bus_byte_enables_n_in,
  output logic      [3:0]              bus_byte_enables_n_out,
  output logic                         bus_byte_enables_n_oe,
  output logic                         upper_address_latch_strobe_n,
  output logic                         data_transceiver_direction,
  output logic                         upper_half_lane_buffer_enable_n,
  output logic                         lane_one_buffer_enable_n,
  output logic                         lane_zero_buffer_enable_n
);
  import eab_pkg::*;

  typedef struct packed {
    eab_phase_e  ph;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
    logic [31:0] dout;
    logic        doe;
    logic [31:0] rdata;
    logic [7:0]  aout;
    logic        aoe;
    logic [3:0]  beout;
    logic        beoe;
    logic        ack;
    logic        start_n;
    logic        busy;
    eab_buf_s    buf_o;
  } eab_st_s;

  eab_st_s    st_q;
  eab_st_s    st_d;
  eab_sobs_s  obs;
  logic [2:0] lane_n;
  logic       lane_act;
  logic [3:0] lane_be;

  // Address 11..10 only ever read, never driven
  assign obs.cyc     = slave_cyc && (st_q.ph == EAB_IDLE || st_q.ph == EAB_SLAVE); // see RULE_05
  assign obs.write   = slave_write;
  assign obs.addr_hi = slave_upper_decode_address_inputs; // see RULE_05
  assign obs.addr_lo = lower_bus_address_lines_in;        // see RULE_08
  assign obs.be_n    = bus_byte_enables_n_in;             // see RULE_10

  eab_decode u_dec (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .obs     (obs),
    .dec     (io_dec)
  );

  // Lanes open only once direction has settled a cycle earlier
  assign lane_act = (st_q.ph == EAB_DATA) ||
                    (st_q.ph == EAB_SLAVE && slave_cyc &&
                     st_q.buf_o.dir == (slave_write ? DIR_TO_DEV : DIR_TO_BUS)
                     && (slave_write || slave_rd_data_ok)); // see RULE_16
  assign lane_be  = (st_q.ph == EAB_SLAVE) ? bus_byte_enables_n_in : st_q.be_n;

  eab_lane_ctl u_lane (
    .active    (lane_act),
    .be_n      (lane_be),
    .lane_en_n (lane_n)
  );

  always_comb
  begin
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.buf_o.lane_en_n = lane_n; // see RULE_15
    case (st_q.ph)
      EAB_IDLE:
      begin
        st_d.start_n = 1'b1;
        st_d.buf_o.strobe_n = STROBE_RST; // see RULE_13
        if (mreq.req)
        begin
          st_d.ph    = EAB_ADDR;
          st_d.busy  = 1'b1;
          st_d.write = mreq.write;
          st_d.addr  = mreq.addr;
          st_d.be_n  = mreq.be_n;
          st_d.wdata = mreq.wdata;
          st_d.dout  = {mreq.addr[31:UP_ADDR_LSB], 10'h000}; // see RULE_03
          st_d.doe   = 1'b1;                                // see RULE_11
          st_d.buf_o.dir = DIR_TO_BUS;
        end
        else if (slave_cyc)
        begin
          st_d.ph = EAB_SLAVE;
        end
      end
      EAB_ADDR:
      begin
        // Strobe falls one clock ahead of the start strobe
        st_d.buf_o.strobe_n = 1'b0; // see RULE_12
        st_d.aout  = st_q.addr[9:2];  // see RULE_06
        st_d.aoe   = 1'b1;
        st_d.beout = st_q.be_n;       // see RULE_10
        st_d.beoe  = 1'b1;
        st_d.ph    = EAB_START;
      end
      EAB_START:
      begin
        st_d.start_n = 1'b0;
        st_d.dout = st_q.wdata;
        st_d.doe  = st_q.write;
        st_d.buf_o.dir = st_q.write ? DIR_TO_BUS : DIR_TO_DEV; // see RULE_14
        st_d.ph   = EAB_DATA;
      end
      EAB_DATA:
      begin
        st_d.start_n = 1'b1;
        st_d.ph = EAB_TURN;
      end
      EAB_TURN:
      begin
        // Lanes open only from here, so read data is sampled now
        if (!st_q.write)
          st_d.rdata = data_in; // see RULE_15
        // Lower address released here; slave must latch it
        st_d.buf_o.strobe_n = STROBE_RST; // see RULE_12
        st_d.doe  = 1'b0;
        st_d.aoe  = 1'b0;
        st_d.beoe = 1'b0;
        st_d.busy = 1'b0;
        st_d.ack  = 1'b1;
        st_d.buf_o.dir = DIR_TO_DEV;
        st_d.ph   = EAB_IDLE;
      end
      EAB_SLAVE:
      begin
        st_d.buf_o.strobe_n = STROBE_RST; // see RULE_13
        st_d.aoe  = 1'b0;                 // see RULE_08
        st_d.beoe = 1'b0;                 // see RULE_10
        st_d.doe  = 1'b0;
        st_d.buf_o.dir = slave_write ? DIR_TO_DEV : DIR_TO_BUS; // see RULE_14
        if (!slave_cyc)
        begin
          st_d.buf_o.dir = DIR_TO_DEV;
          st_d.ph = EAB_IDLE;
        end
      end
      default:
      begin
        st_d.ph = EAB_IDLE;
      end
    endcase
  end

  // Reset floats the data, address and byte-enable pins and parks outputs inactive
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q                 <= '0;             // see RULE_01
      st_q.ph              <= EAB_IDLE;
      st_q.start_n         <= 1'b1;
      st_q.buf_o.strobe_n  <= STROBE_RST;     // see RULE_13
      st_q.buf_o.dir       <= DIR_RST;        // see RULE_14
      st_q.buf_o.lane_en_n <= LANE_EN_RST_N;  // see RULE_15
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign mreq_ack                        = st_q.ack;
  assign start_n                         = st_q.start_n;
  assign master_busy                     = st_q.busy;
  assign data_out                        = st_q.dout;
  assign data_oe                         = st_q.doe;  // see RULE_04
  assign rdata                           = st_q.rdata;
  assign lower_bus_address_lines_out     = st_q.aout;
  assign lower_bus_address_lines_oe      = st_q.aoe;
  assign bus_byte_enables_n_out          = st_q.beout;
  assign bus_byte_enables_n_oe           = st_q.beoe;
  assign upper_address_latch_strobe_n    = st_q.buf_o.strobe_n;
  assign data_transceiver_direction      = st_q.buf_o.dir;
  assign upper_half_lane_buffer_enable_n = st_q.buf_o.lane_en_n[2];
  assign lane_one_buffer_enable_n        = st_q.buf_o.lane_en_n[1];
  assign lane_zero_buffer_enable_n       = st_q.buf_o.lane_en_n[0];

  sequence s_strobe_then_start;
    $fell(upper_address_latch_strobe_n) ##1 $fell(start_n);
  endsequence

  a_strobe_lead: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_12
    $fell(upper_address_latch_strobe_n) |-> s_strobe_then_start)
    else $error("strobe not one clock before start");
  a_strobe_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_12
    $fell(start_n) |-> !upper_address_latch_strobe_n [*2])
    else $error("strobe released early");
  a_slave_strobe: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_13
    (st_q.ph == EAB_SLAVE) |-> upper_address_latch_strobe_n)
    else $error("strobe low in slave mode");
  a_upper_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_11
    (st_q.ph == EAB_IDLE && mreq.req) |=> data_oe && data_out[31:10] == $past(mreq.addr[31:10]))
    else $error("upper address not placed");
  a_low_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_06
    $fell(upper_address_latch_strobe_n) |-> lower_bus_address_lines_oe
      && lower_bus_address_lines_out == st_q.addr[9:2])
    else $error("lower address not driven");
  a_slave_float: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_08
    (st_q.ph == EAB_SLAVE) |=> !lower_bus_address_lines_oe && !bus_byte_enables_n_oe)
    else $error("address lines driven in slave mode");
  a_dir_write: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_14
    (st_q.ph == EAB_DATA && st_q.write) |-> data_transceiver_direction == DIR_TO_BUS)
    else $error("direction wrong on master write");
  a_lane_settle: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_16
    $changed(data_transceiver_direction) |-> (&{upper_half_lane_buffer_enable_n,
      lane_one_buffer_enable_n, lane_zero_buffer_enable_n}))
    else $error("lanes enabled while direction changes");
  a_be_drive: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_10
    (st_q.ph == EAB_START) |-> bus_byte_enables_n_oe && bus_byte_enables_n_out == st_q.be_n)
    else $error("byte enables not driven");
endmodule
`default_nettype wire

/* pkg/eab_pkg.sv */
// Constants and carrier types for the bus address/data buffer control block
package eab_pkg;
  localparam int unsigned RST_MIN_CYCLES  = 8;
  localparam int unsigned UP_ADDR_W       = 22;
  localparam int unsigned UP_ADDR_LSB     = 10;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned LOW_ADDR_W      = 8;
  localparam int unsigned BE_W            = 4;
  localparam logic        STROBE_RST      = 1'b1;
  localparam logic        DIR_RST         = 1'b1;
  localparam logic        DIR_TO_BUS      = 1'b0;
  localparam logic        DIR_TO_DEV      = 1'b1;
  localparam logic [2:0]  LANE_EN_RST_N   = 3'h7;
  localparam logic [9:0]  SLOT_IO_BASE    = 10'h000;
  localparam logic [9:0]  SHARED_REG_BASE = 10'h030;
  localparam logic [3:0]  SHARED_BE_MASK  = 4'hF;
  localparam logic [7:0]  GEN_IO_BASE     = 8'h00;

  typedef enum logic [2:0] {
    EAB_IDLE   = 3'b000,
    EAB_ADDR   = 3'b001,
    EAB_START  = 3'b011,
    EAB_DATA   = 3'b010,
    EAB_TURN   = 3'b110,
    EAB_SLAVE  = 3'b111
  } eab_phase_e;

  // Master transfer request from the core
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } eab_mreq_s;

  // Slave-side bus observation
  typedef struct packed {
    logic        cyc;
    logic        write;
    logic [1:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic [3:0]  be_n;
  } eab_sobs_s;

  typedef struct packed {
    logic slot_io;
    logic shared_reg;
    logic gen_io;
  } eab_dec_s;

  typedef struct packed {
    logic       strobe_n;
    logic       dir;
    logic [2:0] lane_en_n;
  } eab_buf_s;
endpackage

/* design/eab_decode.sv */
// Slave I/O decode of slot specific, shared register and general address sets
`timescale 1ns/1ps
`default_nettype none
module eab_decode
  import eab_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  input  wire eab_pkg::eab_sobs_s   obs,
  output var  eab_pkg::eab_dec_s    dec
);
  import eab_pkg::*;

  typedef struct packed {
    eab_dec_s dec;
  } eab_dst_s;

  eab_dst_s st_q;
  eab_dst_s st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.dec.slot_io    = obs.cyc && ({obs.addr_hi, obs.addr_lo} == SLOT_IO_BASE); // see RULE_09
    st_d.dec.shared_reg = obs.cyc && ({obs.addr_hi, obs.addr_lo} == SHARED_REG_BASE)
                          && ((~obs.be_n & SHARED_BE_MASK) != 4'h0); // see RULE_09
    st_d.dec.gen_io     = obs.cyc && (obs.addr_lo == GEN_IO_BASE); // see RULE_09
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign dec = st_q.dec;

  a_gen_decode: assert property (@(posedge clk_sys) disable iff (!nrst) // see RULE_09
    (obs.cyc && obs.addr_lo == GEN_IO_BASE) |=> dec.gen_io)
    else $error("general decode missed");
endmodule
`default_nettype wire

/* design/eab_lane_ctl.sv */
// Byte-lane transceiver enable mapping from active byte enables
`timescale 1ns/1ps
`default_nettype none
module eab_lane_ctl
  import eab_pkg::*;
(
  input  wire logic        active,
  input  wire logic [3:0]  be_n,
  output logic      [2:0]  lane_en_n
);
  import eab_pkg::*;

  // Upper enable covers lanes two and three together
  always_comb
  begin
    lane_en_n = LANE_EN_RST_N;
    if (active)
    begin
      lane_en_n[2] = be_n[3] & be_n[2]; // see RULE_16
      lane_en_n[1] = be_n[1];           // see RULE_16
      lane_en_n[0] = be_n[0];           // see RULE_16
    end
  end
endmodule
`default_nettype wire

/* sim/eab_bus_model.sv */
// Bus-side partner: transceivers, upper address latch and bus wires
`timescale 1ns/1ps
`default_nettype none
module eab_bus_model
  import eab_pkg::*;
(
  input  wire logic [31:0] d_out,
  input  wire logic        clk_sys,
  input  wire logic        d_oe,
  input  wire logic [7:0]  a_out,
  input  wire logic        a_oe,
  input  wire logic [3:0]  b_out,
  input  wire logic        b_oe,
  input  wire logic        stb_n,
  input  wire logic        st_n,
  input  wire logic        dir,
  input  wire logic [2:0]  ln_n,
  input  wire logic        s_drv,
  input  wire logic [7:0]  s_a,
  input  wire logic [3:0]  s_b,
  input  wire logic [31:0] rd_w,
  output logic      [31:0] d_in,
  output logic      [7:0]  a_in,
  output logic      [3:0]  b_in,
  output logic      [21:0] lat_up,
  output logic      [7:0]  lat_lo,
  output logic      [3:0]  lat_be,
  output logic      [31:0] wr_w
);
  logic [31:0] last_d = 32'h0;
  logic [7:0]  last_a = 8'h00;
  logic [3:0]  last_b = 4'h0;
  logic [3:0]  on;
  assign on = {~ln_n[2], ~ln_n[2], ~ln_n[1], ~ln_n[0]};
  // Released lines toggle so a stale value never looks valid
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      d_in[8*k +: 8] = (on[k] && dir) ? rd_w[8*k +: 8] : ~last_d[8*k +: 8];
  end
  assign a_in = a_oe ? a_out : (s_drv ? s_a : ~last_a);
  assign b_in = b_oe ? b_out : (s_drv ? s_b : ~last_b);
  always @(posedge clk_sys)
  begin
    last_d <= d_in;
    last_a <= a_in;
    last_b <= b_in;
    if (!st_n)
    begin
      lat_lo <= a_in;
      lat_be <= b_in;
    end
    if (!dir)
      for (int k = 0; k < 4; k++)
        if (on[k])
          wr_w[8*k +: 8] <= d_out[8*k +: 8];
  end
  // External latch closes on the strobe fall
  always @(negedge stb_n)
    lat_up <= d_oe ? d_out[31:10] : ~d_out[31:10];
endmodule
`default_nettype wire

/* sim/eab_buf_ctl_tb_top.sv */
// Self-checking bench for the bus address/data buffer control block
`timescale 1ns/1ps
`default_nettype none
module eab_buf_ctl_tb_top;
  import eab_pkg::*;
  typedef struct packed
  {
    logic        w;
    logic [21:0] up;
    logic [7:0]  lo;
    logic [3:0]  be;
    logic [31:0] d;
    logic [31:0] m;
  } eab_note_s;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  eab_mreq_s   mreq = '0;
  logic        s_cyc = 1'b0, s_wr = 1'b0, rd_ok = 1'b0, s_drv = 1'b0;
  logic [1:0]  s_hi = 2'h0;
  logic [7:0]  s_a = 8'h00;
  logic [3:0]  s_b = 4'hF;
  logic [31:0] rd_w = 32'h0;
  logic        ack, st_n, busy, d_oe, a_oe, b_oe, stb_n, dir;
  logic [2:0]  ln;
  eab_dec_s    dec;
  logic [31:0] d_in, d_out, rdata, wr_w;
  logic [7:0]  a_in, a_out, lat_lo;
  logic [3:0]  b_in, b_out, lat_be;
  logic [21:0] lat_up;
  int          err_count = 0;
  int          n_tests = 0;
  eab_note_s   notes[$];

  eab_buf_ctl eab_buf_ctl_inst (.clk_sys(clk_sys), .nrst(nrst), .mreq(mreq), .mreq_ack(ack),
    .start_n(st_n), .master_busy(busy), .slave_cyc(s_cyc), .slave_write(s_wr),
    .slave_rd_data_ok(rd_ok), .io_dec(dec), .data_in(d_in), .data_out(d_out), .data_oe(d_oe),
    .rdata(rdata), .slave_upper_decode_address_inputs(s_hi), .lower_bus_address_lines_in(a_in),
    .lower_bus_address_lines_out(a_out), .lower_bus_address_lines_oe(a_oe),
    .bus_byte_enables_n_in(b_in), .bus_byte_enables_n_out(b_out), .bus_byte_enables_n_oe(b_oe),
    .upper_address_latch_strobe_n(stb_n), .data_transceiver_direction(dir),
    .upper_half_lane_buffer_enable_n(ln[2]), .lane_one_buffer_enable_n(ln[1]),
    .lane_zero_buffer_enable_n(ln[0]));
  eab_bus_model eab_bus_model_inst (.clk_sys(clk_sys), .d_out(d_out), .d_oe(d_oe),
    .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .stb_n(stb_n), .st_n(st_n),
    .dir(dir), .ln_n(ln), .s_drv(s_drv), .s_a(s_a), .s_b(s_b), .rd_w(rd_w), .d_in(d_in),
    .a_in(a_in), .b_in(b_in), .lat_up(lat_up), .lat_lo(lat_lo), .lat_be(lat_be), .wr_w(wr_w));

  initial
    forever #12.5 clk_sys = ~clk_sys;

  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] lmask(input logic [3:0] b);
    return {{16{~b[2] | ~b[3]}}, {8{~b[1]}}, {8{~b[0]}}};
  endfunction

  // Back-to-back capable: returns at the ack cycle, next request may follow at once
  task automatic master(input logic wr);
    eab_note_s n;
    int i;
    mreq = '{req: 1'b1, write: wr, addr: $urandom, be_n: 4'($urandom_range(0, 14)),
             wdata: $urandom};
    rd_w = $urandom;
    n = '{w: wr, up: mreq.addr[31:10], lo: mreq.addr[9:2], be: mreq.be_n, d: 32'h0,
          m: lmask(mreq.be_n)};
    n.d = (wr ? mreq.wdata : rd_w) & n.m;
    notes.push_back(n);
    i = 0;
    while (stb_n !== 1'b0 && i < 8)
    begin
      step();
      i++;
    end
    chk({st_n, busy}, 2'b11);
    step();
    mreq.req = 1'b0;
    chk({stb_n, st_n}, 2'b00);
    step();
    chk({stb_n, ln, dir}, {1'b0, n.be[2] & n.be[3], n.be[1:0], ~wr});
    step();
    chk({ack, stb_n, dir, a_oe, b_oe, busy}, 6'b111000);
  endtask

  task automatic slave(input logic [1:0] hi, input logic [7:0] lo, input logic [3:0] b,
                       input logic wr);
    logic [2:0] e;
    e = {{hi, lo} == SLOT_IO_BASE, {hi, lo} == SHARED_REG_BASE && (b & SHARED_BE_MASK) != 4'hF,
         lo == GEN_IO_BASE};
    s_hi = hi;
    s_a = lo;
    s_b = b;
    s_drv = 1'b1;
    s_cyc = 1'b1;
    s_wr = wr;
    repeat (3) step();
    chk(dec, e);
    chk({stb_n, a_oe, b_oe}, 3'b100);
    rd_ok = ~wr;
    repeat (3) step();
    chk({ln, dir}, {b[2] & b[3], b[1:0], wr});
    s_cyc = 1'b0;
    rd_ok = 1'b0;
    s_drv = 1'b0;
    repeat (3) step();
    chk({ln, dir}, 4'hF);
  endtask

  // Result watcher: each ack retires the oldest expected transfer
  initial
  begin
    eab_note_s n;
    forever
    begin
      @(posedge clk_sys);
      #1;
      if (ack === 1'b1)
      begin
        n = notes.pop_front();
        chk({lat_up, lat_lo, lat_be}, {n.up, n.lo, n.be});
        chk((n.w ? wr_w : rdata) & n.m, n.d);
      end
    end
  end

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    final_report();
  end

  initial
  begin
    void'($urandom(7335));
    repeat (20) step();
    chk({d_oe, a_oe, b_oe, stb_n, dir, ln, st_n, ack}, 10'h07E);
    nrst = 1'b1;
    step();
    $display("reset test done");
    for (int t = 0; t < 8; t++)
      master(t[0]);
    $display("master test done");
    slave(2'h0, 8'h00, 4'hF, 1'b1);
    slave(2'h0, 8'h30, 4'hE, 1'b0);
    slave(2'h0, 8'h30, 4'hF, 1'b1);
    slave(2'h1, 8'h00, 4'h0, 1'b0);
    slave(2'($urandom), 8'($urandom), 4'($urandom), 1'($urandom));
    $display("slave test done");
    mreq.req = 1'b1;
    repeat (3) step();
    nrst = 1'b0;
    #3;
    chk({d_oe, stb_n, dir, ln}, 6'h1F);
    mreq.req = 1'b0;
    repeat (20) step();
    nrst = 1'b1;
    step();
    master(1'b0);
    step();
    $display("mid-run reset test done");
    final_report();
  end
endmodule
`default_nettype wire
